//--- core/fbcr_channel_regs.sv
// Frame buffer channel registers, transmit word FIFO and channel logic
//
// Summary of operation
// - Size prefix bit set: packet byte count is written as first long word.
// - Engine interrupt pass-through works only in the primary channel.
// - Engine pass-through interrupt reaches CPU only with channel interrupt enabled.
// - Three-bit priority at bits 15..13; primary copy only is used.
// - Three-bit context at bits 10..8, codes 0..4; primary copy only used.
// - Control bit 7 enables the channel; disabled channel moves no data.
// - Writing 1 to bit 6 starts transmit if enabled; 0 does nothing.
// - Bits 4, 3, 2 enable interrupt on transmit done, receive, error.
// - Mode 00 is FIFO via data ports; 01 is random access.
// - Status is read-only and resets to 0x00000400.
// - Status bit 10 reads 1 while receive pointers are equal.
// - Status bit 9 reads 1 when transmit read pointer is one location ahead.
// - Status bit 7 set on interrupt, cleared by status read.
// - Status bit 3 set when receive write pointer passes read pointer.
// - Status bit 2 set on engine error, cleared by status read.
// - Status bit 1 set on received packet, cleared by status read.
// - Status bit 0 set on transmit done, cleared by read or start.
// - Twelve-bit transmit size in bytes, used in both modes.
// - Thirteen-bit receive size, even-rounded, restarts for each packet.
// - Receive start reads low bits 00; receive end reads low bits 11.
// - Transmit start is long-word aligned with read-only low bits 00.
// - Each channel has its own dedicated register set on the CPU port.
// - Channel interrupt ORs enabled sources, plus engine interrupt in primary.
// - FIFO-mode receive data read returns word and advances pointer by four.
// - Data moves to and from the engine as 16-bit words.
`include "fbcr_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

// Word FIFO with registered input ready
module fbcr_word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_allow,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_idx_r;
  logic [AW-1:0] rd_idx_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  logic push;
  logic pop;

  // Handshakes and next fill level
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_idx_r];
  always_comb
  begin
    count_nxt = count_r;
    if (flush)
      count_nxt = '0;
    else if (push && !pop)
      count_nxt = count_r + 1'b1;
    else if (pop && !push)
      count_nxt = count_r - 1'b1;
  end

  // Storage
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem_r[wr_idx_r] <= in_data;
  end

  // Indices, level and ready
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || flush)
    begin
      wr_idx_r <= '0;
      rd_idx_r <= '0;
      count_r <= '0;
      in_ready <= 1'b0;
    end
    else
    begin
      if (push)
        wr_idx_r <= (wr_idx_r == AW'(DEPTH - 1)) ? '0 : wr_idx_r + 1'b1;
      if (pop)
        rd_idx_r <= (rd_idx_r == AW'(DEPTH - 1)) ? '0 : rd_idx_r + 1'b1;
      count_r <= count_nxt;
      in_ready <= in_allow && (count_nxt != (AW + 1)'(DEPTH));
    end
  end

  a_fifo_no_overrun: assert property (@(posedge clk_sys) disable iff (!rst_n)
    count_r <= (AW + 1)'(DEPTH))
    else $error("FIFO level above depth");
endmodule // fbcr_word_fifo

// One channel register set with transmit and receive control
module fbcr_channel_regs #(
  parameter bit PRIMARY = 1'b1,
  parameter int TXW = 12,
  parameter int RXW = 13,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic [RXW-1:0] rx_read_pointer,
  input wire logic [RXW-1:0] rx_write_pointer,
  input wire logic [TXW-1:0] tx_read_pointer,
  input wire logic [TXW-1:0] tx_write_pointer,
  input wire logic [31:0] rx_head_word,
  output logic rx_pop,
  input wire logic tx_word_valid,
  output logic tx_word_ready,
  input wire logic [15:0] tx_word_data,
  output logic eng_tx_valid,
  input wire logic eng_tx_ready,
  output logic [15:0] eng_tx_data,
  input wire logic eng_rx_valid,
  input wire logic eng_rx_last,
  input wire logic [15:0] eng_rx_data,
  output logic rx_store_valid,
  output logic [15:0] rx_store_data,
  output logic rx_prefix_valid,
  output logic [RXW-1:0] rx_prefix_bytes,
  output logic rx_prefix_on,
  input wire logic eng_error,
  input wire logic eng_irq,
  output logic chan_irq,
  output logic [2:0] irq_priority,
  output logic [2:0] irq_context,
  output logic random_access
);
  logic [31:0] ctrl_r;
  logic [TXW-1:0] tx_size_r;
  logic [RXW-1:0] rx_size_r;
  logic [RXW-3:0] rx_begin_r;
  logic [RXW-3:0] rx_last_r;
  logic [TXW-3:0] tx_begin_r;
  logic tx_done_r;
  logic rx_done_r;
  logic err_r;
  logic ovf_r;
  logic irqf_r;
  logic rx_empty_r;
  logic tx_full_r;
  logic rx_new_pkt_r;
  fbcr_pkg::fbcr_tx_state_t tx_state_r;
  fbcr_pkg::fbcr_tx_state_t tx_state_nxt;
  logic [TXW-1:0] fetch_left_r;
  logic [TXW-1:0] fetch_left_nxt;
  logic wr_ctrl;
  logic wr_txsz;
  logic rd_stat;
  logic tx_go;
  logic chan_en;
  logic fifo_mode;
  logic irq_nxt;
  logic tx_finish;
  logic fetch_push;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [15:0] fifo_out_data;
  logic [31:0] status_word;

  // Address match helper
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // Register port decode; each channel owns a private set
  assign wr_ctrl = reg_wr && hit(reg_addr, `FBCR_OFS_CTRL);
  assign wr_txsz = reg_wr && hit(reg_addr, `FBCR_OFS_TXSZ);
  assign rd_stat = reg_rd && hit(reg_addr, `FBCR_OFS_STAT);
  assign chan_en = ctrl_r[`FBCR_C_CHEN];
  assign fifo_mode = (ctrl_r[`FBCR_C_MODE_HI:`FBCR_C_MODE_LO] == fbcr_pkg::FBCR_MODE_FIFO);
  assign tx_go = wr_ctrl && reg_wdata[`FBCR_C_TXGO] && chan_en;

  // Control register; start bit is a strobe and never stored
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      ctrl_r <= `FBCR_CTRL_RST;
    else if (wr_ctrl)
      ctrl_r <= reg_wdata & `FBCR_CTRL_MASK;
  end

  // Size and buffer bound registers
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      tx_size_r <= '0;
      rx_begin_r <= '0;
      rx_last_r <= (RXW - 2)'(`FBCR_RXLAST_RST >> 2);
      tx_begin_r <= '0;
    end
    else if (reg_wr)
    begin
      if (wr_txsz)
        tx_size_r <= reg_wdata[TXW-1:0];
      if (hit(reg_addr, `FBCR_OFS_RXBEG))
        rx_begin_r <= reg_wdata[RXW-1:2];
      if (hit(reg_addr, `FBCR_OFS_RXLAST))
        rx_last_r <= reg_wdata[RXW-1:2];
      if (hit(reg_addr, `FBCR_OFS_TXBEG))
        tx_begin_r <= reg_wdata[TXW-1:2];
    end
  end

  // Receive side: even byte count, restart per packet, prefix at packet end
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rx_size_r <= '0;
      rx_new_pkt_r <= 1'b1;
      rx_store_valid <= 1'b0;
      rx_store_data <= 16'h0000;
      rx_prefix_valid <= 1'b0;
      rx_prefix_bytes <= '0;
    end
    else
    begin
      rx_store_valid <= eng_rx_valid && chan_en;
      rx_store_data <= eng_rx_data;
      rx_prefix_valid <= 1'b0;
      if (reg_wr && hit(reg_addr, `FBCR_OFS_RXSZ))
        rx_size_r <= reg_wdata[RXW-1:0];
      else if (eng_rx_valid && chan_en)
      begin
        rx_size_r <= rx_new_pkt_r ? RXW'(`FBCR_WORD_BYTES)
                                  : rx_size_r + RXW'(`FBCR_WORD_BYTES);
        rx_new_pkt_r <= eng_rx_last;
        if (eng_rx_last && ctrl_r[`FBCR_C_RXPFX])
        begin
          rx_prefix_valid <= 1'b1;
          rx_prefix_bytes <= rx_new_pkt_r ? RXW'(`FBCR_WORD_BYTES)
                                          : rx_size_r + RXW'(`FBCR_WORD_BYTES);
        end
      end
    end
  end

  // Transmit sequencer: fetch the packet's words, finish when drained
  always_comb
  begin
    tx_state_nxt = tx_state_r;
    fetch_left_nxt = fetch_left_r;
    tx_finish = 1'b0;
    case (tx_state_r)
      fbcr_pkg::FBCR_TX_IDLE:
      begin
        if (tx_go && (tx_size_r != '0))
        begin
          tx_state_nxt = fbcr_pkg::FBCR_TX_RUN;
          fetch_left_nxt = (tx_size_r >> 1) + TXW'(tx_size_r[0]);
        end
      end
      fbcr_pkg::FBCR_TX_RUN:
      begin
        if (fetch_push)
          fetch_left_nxt = fetch_left_r - 1'b1;
        if (!chan_en)
          tx_state_nxt = fbcr_pkg::FBCR_TX_IDLE;
        else if (fetch_left_r == '0 && !fifo_out_valid && !eng_tx_valid)
        begin
          tx_state_nxt = fbcr_pkg::FBCR_TX_IDLE;
          tx_finish = 1'b1;
        end
      end
      default:
        tx_state_nxt = fbcr_pkg::FBCR_TX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      tx_state_r <= fbcr_pkg::FBCR_TX_IDLE;
      fetch_left_r <= '0;
    end
    else
    begin
      tx_state_r <= tx_state_nxt;
      fetch_left_r <= fetch_left_nxt;
    end
  end

  assign fetch_push = tx_word_valid && tx_word_ready;

  // Transmit word buffer between frame buffer and engine
  fbcr_word_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .flush(!chan_en),
    .in_allow((tx_state_nxt == fbcr_pkg::FBCR_TX_RUN) && (fetch_left_nxt != '0)),
    .in_valid(tx_word_valid),
    .in_ready(tx_word_ready),
    .in_data(tx_word_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Output stage toward the engine, 16-bit words
  assign fifo_out_ready = !eng_tx_valid || eng_tx_ready;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || !chan_en)
    begin
      eng_tx_valid <= 1'b0;
      eng_tx_data <= 16'h0000;
    end
    else if (fifo_out_ready)
    begin
      eng_tx_valid <= fifo_out_valid;
      eng_tx_data <= fifo_out_data;
    end
  end

  // Pointer compares for buffer empty and full
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rx_empty_r <= 1'b1;
      tx_full_r <= 1'b0;
    end
    else
    begin
      rx_empty_r <= (rx_read_pointer == rx_write_pointer);
      tx_full_r <= (tx_read_pointer == tx_write_pointer + TXW'(`FBCR_TX_LOC));
    end
  end

  // Sticky event flags; a new event wins over the read clear
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      tx_done_r <= 1'b0;
      rx_done_r <= 1'b0;
      err_r <= 1'b0;
      ovf_r <= 1'b0;
      irqf_r <= 1'b0;
    end
    else
    begin
      tx_done_r <= tx_finish || (tx_done_r && !rd_stat && !tx_go);
      rx_done_r <= (eng_rx_valid && eng_rx_last && chan_en) || (rx_done_r && !rd_stat);
      err_r <= eng_error || (err_r && !rd_stat);
      ovf_r <= (eng_rx_valid && chan_en && !rx_empty_r
               && rx_write_pointer + RXW'(`FBCR_WORD_BYTES) == rx_read_pointer)
               || (ovf_r && !rd_stat);
      irqf_r <= (irq_nxt && !chan_irq) || (irqf_r && !rd_stat);
    end
  end

  // Channel interrupt from enabled sources
  assign irq_nxt = ctrl_r[`FBCR_C_IE]
    && ((ctrl_r[`FBCR_C_TXIE] && tx_done_r)
     || (ctrl_r[`FBCR_C_RXIE] && rx_done_r)
     || (ctrl_r[`FBCR_C_ERIE] && err_r)
     || (PRIMARY && ctrl_r[`FBCR_C_ENGIE] && eng_irq));

  // Interrupt and routing outputs
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      chan_irq <= 1'b0;
      irq_priority <= 3'h0;
      irq_context <= 3'h0;
      random_access <= 1'b0;
      rx_prefix_on <= 1'b0;
    end
    else
    begin
      chan_irq <= irq_nxt;
      irq_priority <= PRIMARY ? ctrl_r[`FBCR_C_PRI_HI:`FBCR_C_PRI_LO] : 3'h0;
      irq_context <= PRIMARY ? ctrl_r[`FBCR_C_CTX_HI:`FBCR_C_CTX_LO] : 3'h0;
      random_access <= (ctrl_r[`FBCR_C_MODE_HI:`FBCR_C_MODE_LO]
                        == fbcr_pkg::FBCR_MODE_RAND);
      rx_prefix_on <= ctrl_r[`FBCR_C_RXPFX];
    end
  end

  // Status word; reserved bits zero
  always_comb
  begin
    status_word = 32'h00000000;
    status_word[`FBCR_S_RXEMPTY] = rx_empty_r;
    status_word[`FBCR_S_TXFULL] = tx_full_r;
    status_word[`FBCR_S_IRQF] = irqf_r;
    status_word[`FBCR_S_OVF] = ovf_r;
    status_word[`FBCR_S_ERR] = err_r;
    status_word[`FBCR_S_RXDONE] = rx_done_r;
    status_word[`FBCR_S_TXDONE] = tx_done_r;
  end

  // Read data, one cycle after the read strobe; receive port pops in FIFO mode
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 32'h00000000;
      rx_pop <= 1'b0;
    end
    else
    begin
      rx_pop <= reg_rd && hit(reg_addr, `FBCR_OFS_RXDATA) && fifo_mode && chan_en;
      if (reg_rd)
      begin
        case (reg_addr)
          `FBCR_OFS_CTRL: reg_rdata <= ctrl_r;
          `FBCR_OFS_STAT: reg_rdata <= status_word;
          `FBCR_OFS_TXSZ: reg_rdata <= 32'(tx_size_r);
          `FBCR_OFS_RXSZ: reg_rdata <= 32'(rx_size_r);
          `FBCR_OFS_RXBEG: reg_rdata <= 32'({rx_begin_r, `FBCR_LOW_ZERO});
          `FBCR_OFS_RXLAST: reg_rdata <= 32'({rx_last_r, `FBCR_LOW_ONES});
          `FBCR_OFS_TXBEG: reg_rdata <= 32'({tx_begin_r, `FBCR_LOW_ZERO});
          `FBCR_OFS_RXDATA: reg_rdata <= fifo_mode ? rx_head_word : 32'h00000000;
          default: reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  a_status_reset_val: assert property (@(posedge clk_sys)
    $rose(rst_n) |-> status_word == `FBCR_STAT_RST)
    else $error("Status not at reset value");
  a_disabled_no_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_ctrl && !chan_en) |=> tx_state_r == fbcr_pkg::FBCR_TX_IDLE
      || $past(tx_state_r) == fbcr_pkg::FBCR_TX_RUN)
    else $error("Transmit started while disabled");
  a_txdone_start_clr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (tx_go && !tx_finish) |=> !tx_done_r)
    else $error("Transmit done not cleared by start");
  a_stat_read_clr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rd_stat && !eng_error) |=> !err_r ##1 reg_rdata[`FBCR_S_ERR] == $past(err_r, 2))
    else $error("Error flag not cleared by read");
  a_error_sets: assert property (@(posedge clk_sys) disable iff (!rst_n)
    eng_error |=> err_r)
    else $error("Error flag not set");
  a_pass_through: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (eng_irq && ctrl_r[`FBCR_C_ENGIE] && !ctrl_r[`FBCR_C_IE]) |=> !chan_irq)
    else $error("Engine interrupt passed without channel enable");
  a_route_copy: assert property (@(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> irq_priority == (PRIMARY ? $past(ctrl_r[`FBCR_C_PRI_HI:`FBCR_C_PRI_LO]) : 3'h0)
      && irq_context == (PRIMARY ? $past(ctrl_r[`FBCR_C_CTX_HI:`FBCR_C_CTX_LO]) : 3'h0))
    else $error("Priority or context not routed from control");
  a_irq_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (irq_nxt && !chan_irq) |=> irqf_r)
    else $error("Interrupt flag not set");
  a_rx_size_even: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(eng_rx_valid && chan_en && rx_new_pkt_r && !reg_wr)
      |-> rx_size_r == RXW'(`FBCR_WORD_BYTES))
    else $error("Receive size did not restart");
  a_rx_pop_mode: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rx_pop |-> $past(fifo_mode) && $past(reg_rd))
    else $error("Receive pop outside FIFO mode");
  a_disable_drops: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !chan_en |=> !eng_tx_valid)
    else $error("Data moved while channel disabled");
endmodule // fbcr_channel_regs

`default_nettype wire

//--- core/fbcr_cfg.svh
// Offsets, field positions, reset values and sizes of the channel register set
`ifndef FBCR_CFG_SVH
`define FBCR_CFG_SVH
// Register byte offsets on the channel register port
`define FBCR_OFS_CTRL 8'h00
`define FBCR_OFS_STAT 8'h04
`define FBCR_OFS_TXSZ 8'h08
`define FBCR_OFS_RXSZ 8'h0C
`define FBCR_OFS_RXBEG 8'h10
`define FBCR_OFS_RXLAST 8'h14
`define FBCR_OFS_TXBEG 8'h18
`define FBCR_OFS_RXDATA 8'h1C
// Control fields
`define FBCR_C_RXPFX 18
`define FBCR_C_ENGIE 17
`define FBCR_C_IE 16
`define FBCR_C_PRI_HI 15
`define FBCR_C_PRI_LO 13
`define FBCR_C_CTX_HI 10
`define FBCR_C_CTX_LO 8
`define FBCR_C_CHEN 7
`define FBCR_C_TXGO 6
`define FBCR_C_TXIE 4
`define FBCR_C_RXIE 3
`define FBCR_C_ERIE 2
`define FBCR_C_MODE_HI 1
`define FBCR_C_MODE_LO 0
`define FBCR_CTRL_MASK 32'h0007E79F
`define FBCR_CTRL_RST 32'h00000000
// Status fields
`define FBCR_S_RXEMPTY 10
`define FBCR_S_TXFULL 9
`define FBCR_S_IRQF 7
`define FBCR_S_OVF 3
`define FBCR_S_ERR 2
`define FBCR_S_RXDONE 1
`define FBCR_S_TXDONE 0
`define FBCR_STAT_RST 32'h00000400
// Buffer bound registers
`define FBCR_RXLAST_RST 32'h00000011
`define FBCR_LOW_ZERO 2'h0
`define FBCR_LOW_ONES 2'h3
// Transfer unit sizes in bytes
`define FBCR_WORD_BYTES 2
`define FBCR_TX_LOC 4
`endif

//--- core/fbcr_pkg.sv
// Types shared by the frame buffer channel register set
package fbcr_pkg;
  typedef enum logic [1:0] {
    FBCR_TX_IDLE = 2'b01,
    FBCR_TX_RUN = 2'b10
  } fbcr_tx_state_t;
  typedef enum logic [1:0] {
    FBCR_MODE_FIFO = 2'h0,
    FBCR_MODE_RAND = 2'h1
  } fbcr_mode_t;
endpackage

//--- tb/fbcr_engine_model.sv
// Behavioural protocol engine on the far side of the channel
`timescale 1ns/100ps
`default_nettype none
module fbcr_engine_model (
  input wire logic clk_sys,
  input wire logic eng_tx_valid,
  output logic eng_tx_ready,
  input wire logic [15:0] eng_tx_data,
  output logic eng_rx_valid,
  output logic eng_rx_last,
  output logic [15:0] eng_rx_data,
  output logic eng_error,
  output logic eng_irq,
  output int tx_count,
  output logic [15:0] tx_word
);
  int stall = 0;
  // Idle values at time zero
  initial
  begin
    eng_tx_ready = 1'b0;
    eng_rx_valid = 1'b0;
    eng_rx_last = 1'b0;
    eng_rx_data = 16'h0000;
    eng_error = 1'b0;
    eng_irq = 1'b0;
    tx_count = 0;
    tx_word = 16'h0000;
  end
  // Ready toggles each cycle when slow
  always @(negedge clk_sys)
    eng_tx_ready = (stall == 0) ? 1'b1 : ~eng_tx_ready;
  // Word taken at the edge that sees ready
  always @(posedge clk_sys)
    if (eng_tx_valid && eng_tx_ready)
    begin
      tx_count++;
      tx_word = eng_tx_data;
    end
  // Back to back 16-bit words, last one flagged
  task automatic send_words(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk_sys);
      eng_rx_valid = 1'b1;
      eng_rx_last = (i == n - 1);
      eng_rx_data = 16'h5A00 + 16'(i);
    end
    @(negedge clk_sys);
    eng_rx_valid = 1'b0;
    eng_rx_last = 1'b0;
    eng_rx_data = ~eng_rx_data; // Released line shows no stale word
  endtask
  // One cycle error report
  task automatic pulse_error;
    @(negedge clk_sys);
    eng_error = 1'b1;
    @(negedge clk_sys);
    eng_error = 1'b0;
  endtask
  // Engine interrupt level
  task automatic set_irq(input logic v);
    @(negedge clk_sys);
    eng_irq = v;
  endtask
endmodule // fbcr_engine_model
`default_nettype wire

//--- tb/fbcr_channel_regs_tb.sv
// Self-checking bench for the frame buffer channel register set
`include "fbcr_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module fbcr_channel_regs_tb;
  logic clk_sys, rst_n, reg_wr, reg_rd, rx_pop, tx_word_valid, tx_word_ready;
  logic eng_tx_valid, eng_tx_ready, eng_rx_valid, eng_rx_last, rx_store_valid;
  logic rx_prefix_valid, rx_prefix_on, eng_error, eng_irq, chan_irq, random_access;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rx_head_word, rd_val;
  logic [12:0] rx_read_pointer, rx_write_pointer, rx_prefix_bytes, pre_bytes;
  logic [11:0] tx_read_pointer, tx_write_pointer;
  logic [15:0] tx_word_data, eng_tx_data, eng_rx_data, rx_store_data;
  logic [2:0] irq_priority, irq_context;
  int err_total, num_checks, stores, pops, tx_sent, i;
  fbcr_channel_regs #(.PRIMARY(1'b1)) dut (.clk_sys, .rst_n, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .rx_read_pointer, .rx_write_pointer, .tx_read_pointer,
    .tx_write_pointer, .rx_head_word, .rx_pop, .tx_word_valid, .tx_word_ready,
    .tx_word_data, .eng_tx_valid, .eng_tx_ready, .eng_tx_data, .eng_rx_valid, .eng_rx_last,
    .eng_rx_data, .rx_store_valid, .rx_store_data, .rx_prefix_valid, .rx_prefix_bytes,
    .rx_prefix_on, .eng_error, .eng_irq, .chan_irq, .irq_priority, .irq_context,
    .random_access);
  fbcr_engine_model eng (.clk_sys, .eng_tx_valid, .eng_tx_ready, .eng_tx_data,
    .eng_rx_valid, .eng_rx_last, .eng_rx_data, .eng_error, .eng_irq, .tx_count(),
    .tx_word());
  // Clock at 125 MHz
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Monitor of datapath side handshakes
  always @(posedge clk_sys)
  begin
    if (rx_store_valid === 1'b1) stores++;
    if (rx_prefix_valid === 1'b1) pre_bytes = rx_prefix_bytes;
    if (rx_pop === 1'b1) pops++;
    if (tx_word_valid && tx_word_ready === 1'b1) tx_sent++;
  end
  // Next transmit word after each taken one
  always @(negedge clk_sys)
    tx_word_data = 16'hA000 + 16'(tx_sent);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata, exp);
  endtask
  task automatic stop_test;
    if (err_total == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Reset values of control, status, receive end and transmit start registers
  task automatic t_reset;
    rdchk(`FBCR_OFS_CTRL, 32'h00000000);
    rdchk(`FBCR_OFS_STAT, 32'h00000400);
    rdchk(`FBCR_OFS_RXLAST, 32'h00000013);
    rdchk(`FBCR_OFS_TXBEG, 32'h00000000);
    chk({31'h0, chan_irq}, 32'h0);
  endtask
  // Masks, read-only bits, field outputs
  task automatic t_fields;
    wr(`FBCR_OFS_CTRL, 32'hFFFFFFBF);
    rdchk(`FBCR_OFS_CTRL, 32'h0007E79F);
    chk({26'h0, irq_priority, irq_context}, 32'h3F);
    chk({31'h0, random_access}, 32'h0);
    wr(`FBCR_OFS_CTRL, 32'h0000A401);
    @(negedge clk_sys);
    chk({26'h0, irq_priority, irq_context}, 32'h2C);
    chk({31'h0, random_access}, 32'h1);
    wr(`FBCR_OFS_CTRL, 32'h0);
    wr(`FBCR_OFS_STAT, 32'hFFFFFFFF);
    rdchk(`FBCR_OFS_STAT, 32'h00000400);
    wr(`FBCR_OFS_TXSZ, 32'hFFFFFFFF);
    rdchk(`FBCR_OFS_TXSZ, 32'h00000FFF);
    wr(`FBCR_OFS_RXBEG, 32'hFFFFFFFF);
    rdchk(`FBCR_OFS_RXBEG, 32'h00001FFC);
    wr(`FBCR_OFS_RXLAST, 32'h0);
    rdchk(`FBCR_OFS_RXLAST, 32'h00000003);
    wr(`FBCR_OFS_TXBEG, 32'hFFFFFFFF);
    rdchk(`FBCR_OFS_TXBEG, 32'h00000FFC);
    rdchk(8'h40, 32'h0);
  endtask
  // Pointer derived status flags
  task automatic t_ptrs;
    tx_read_pointer = 12'h014;
    tx_write_pointer = 12'h010;
    rdchk(`FBCR_OFS_STAT, 32'h00000600);
    tx_write_pointer = 12'h012;
    rx_write_pointer = 13'h0004;
    rdchk(`FBCR_OFS_STAT, 32'h00000000);
    rx_write_pointer = 13'h0000;
    tx_read_pointer = 12'h000;
    tx_write_pointer = 12'h000;
  endtask
  // Odd transmit size against a stalling engine
  task automatic t_tx;
    wr(`FBCR_OFS_TXSZ, 32'h3);
    wr(`FBCR_OFS_CTRL, 32'h40);
    repeat (5) @(negedge clk_sys);
    chk(32'(tx_sent), 32'h0);
    eng.stall = 1;
    wr(`FBCR_OFS_CTRL, 32'h00010090);
    repeat (3) @(negedge clk_sys);
    chk(32'(tx_sent), 32'h0);
    tx_word_valid = 1'b0;
    wr(`FBCR_OFS_CTRL, 32'h000100D0);
    repeat (3) @(negedge clk_sys);
    chk(32'(tx_sent), 32'h0);
    tx_word_valid = 1'b1;
    for (i = 0; i < 100 && eng.tx_count < 2; i++) @(negedge clk_sys);
    repeat (6) @(negedge clk_sys);
    chk(32'(eng.tx_count), 32'h2);
    chk({16'h0, eng.tx_word}, 32'hA001);
    chk({31'h0, chan_irq}, 32'h1);
    rdchk(`FBCR_OFS_STAT, 32'h00000481);
    rdchk(`FBCR_OFS_STAT, 32'h00000400);
    chk({31'h0, chan_irq}, 32'h0);
    eng.stall = 0;
  endtask
  // Packet with size prefix and overflow, then restart and disable
  task automatic t_rx;
    rx_read_pointer = 13'h0010;
    rx_write_pointer = 13'h000E;
    wr(`FBCR_OFS_CTRL, 32'h00050088);
    stores = 0;
    eng.send_words(3);
    repeat (3) @(negedge clk_sys);
    chk(32'(stores), 32'h3);
    chk({19'h0, pre_bytes}, 32'h6);
    chk({31'h0, rx_prefix_on}, 32'h1);
    rdchk(`FBCR_OFS_RXSZ, 32'h6);
    rdchk(`FBCR_OFS_STAT, 32'h0000008A);
    eng.send_words(1);
    repeat (2) @(negedge clk_sys);
    rdchk(`FBCR_OFS_RXSZ, 32'h2);
    wr(`FBCR_OFS_CTRL, 32'h0);
    stores = 0;
    eng.send_words(2);
    repeat (3) @(negedge clk_sys);
    chk(32'(stores), 32'h0);
    rx_read_pointer = 13'h0;
    rx_write_pointer = 13'h0;
    rdchk(`FBCR_OFS_STAT, 32'h0000048A);
    rdchk(`FBCR_OFS_STAT, 32'h00000400);
  endtask
  // Error source and engine pass-through interrupt
  task automatic t_irq;
    wr(`FBCR_OFS_CTRL, 32'h00030084);
    eng.pulse_error();
    repeat (3) @(negedge clk_sys);
    chk({31'h0, chan_irq}, 32'h1);
    rdchk(`FBCR_OFS_STAT, 32'h00000484);
    chk({31'h0, chan_irq}, 32'h0);
    eng.set_irq(1'b1);
    repeat (3) @(negedge clk_sys);
    chk({31'h0, chan_irq}, 32'h1);
    wr(`FBCR_OFS_CTRL, 32'h00020080);
    repeat (2) @(negedge clk_sys);
    chk({31'h0, chan_irq}, 32'h0);
    eng.set_irq(1'b0);
  endtask
  // FIFO mode receive data read
  task automatic t_rxdata;
    wr(`FBCR_OFS_CTRL, 32'h80);
    rx_head_word = 32'h12345678;
    pops = 0;
    rdchk(`FBCR_OFS_RXDATA, 32'h12345678);
    chk(32'(pops), 32'h1);
  endtask
  // Watchdog far beyond the expected run
  initial
  begin
    #200000;
    err_total++;
    stop_test();
  end
  // Main sequence
  initial
  begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, rx_head_word} = '0;
    {rx_read_pointer, rx_write_pointer, tx_read_pointer, tx_write_pointer} = '0;
    {err_total, num_checks, stores, pops, tx_sent} = '0;
    pre_bytes = '0;
    tx_word_valid = 1'b1;
    tx_word_data = 16'hA000;
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    t_reset();
    t_fields();
    t_ptrs();
    t_tx();
    t_rx();
    t_irq();
    t_rxdata();
    stop_test();
  end
endmodule // fbcr_channel_regs_tb
`default_nettype wire
